// ===== hw/xpr_regs.sv
// xram page select, derivative and revision codes, serial number bank
// assumes one register access per cycle from the core, a paged register
// space, and a synchronous-read xram array outside this block
`timescale 1ns/1ns
`include "xpr_defines.svh"

// Summary of operation
// - The page field supplies the upper address byte of short external data moves.
// - Bits 7:2 of the page control register read zero and ignore writes.
// - The page control register answers at 0xAA on every page and resets to zero.
// - A read-only derivative code answers at 0xAB on page 0.
// - A read-only revision code answers at 0xAC on page 0.
// - A 32-bit serial number is loaded at production into four byte registers.
// - Serial byte 3 answers at 0xAE on page F.
// - Serial byte 2 answers at 0xAD on page F.
// - Serial byte 1 answers at 0xAC on page F, the revision code there on page 0.
// - The four serial registers may be written as general storage.
// - Serial byte 0 answers at 0xAB on page F, the derivative code there on page 0.
// - External data reads from 0x0300 to 0x03FF return zero.
// - Pages 0x0 and 0xF exist and the selected page picks the shared-address register.
module xpr_regs #(
    parameter xpr_pkg::xpr_byte_t DERIV_CODE = 8'h5A,  // arbitrary value
    parameter xpr_pkg::xpr_byte_t REV_CODE   = 8'h3C   // arbitrary value
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire xpr_pkg::xpr_byte_t   register_page_selector,
    input  wire xpr_pkg::xpr_byte_t   sfr_addr,
    input  wire logic                 sfr_rd,
    input  wire logic                 sfr_wr,
    input  wire xpr_pkg::xpr_byte_t   sfr_wdata,
    output xpr_pkg::xpr_byte_t        sfr_rdata,
    output logic                      sfr_rack,
    output logic                      sfr_rhit,
    input  wire logic                 sn_load,
    input  wire xpr_pkg::xpr_sn_t     sn_load_value,
    input  wire logic                 external_data_move,
    input  wire logic                 xmove_short,
    input  wire logic                 xmove_wr,
    input  wire xpr_pkg::xpr_maddr_t  xmove_addr,
    input  wire xpr_pkg::xpr_byte_t   xmove_wdata,
    output xpr_pkg::xpr_xaddr_t       xram_addr,
    output logic                      xram_en,
    output logic                      xram_we,
    output xpr_pkg::xpr_byte_t        xram_wdata,
    input  wire xpr_pkg::xpr_byte_t   xram_rdata,
    output xpr_pkg::xpr_byte_t        xmove_rdata,
    output logic                      xmove_rvalid,
    output xpr_pkg::xpr_xram_page_field_t       xram_page_field
);
    import xpr_pkg::*;

    xpr_sel_t    rd_sel;
    xpr_sel_t    wr_sel;
    xpr_byte_t   next_rdata;
    xpr_xaddr_t  next_xaddr;
    logic        next_unpop;
    logic        rd_pend1;
    logic        rd_pend2;
    logic        unpop1;
    logic        unpop2;
    logic        sn_wr_en;
    xpr_sn_idx_t sn_wr_idx;
    xpr_byte_t   sn_byte0;
    xpr_byte_t   sn_byte1;
    xpr_byte_t   sn_byte2;
    xpr_byte_t   sn_byte3;

    // address and page decode shared by reads and writes
    function automatic xpr_sel_t decode_sel(input xpr_byte_t a, input xpr_byte_t pg);
        decode_sel = xpr_sel_none;
        // page control decoded on every page
        if (a == `XPR_ADDR_PAGE_CTRL) begin
            decode_sel = xpr_sel_page_ctrl;
        // page 0 bank of shared addresses
        end else if (pg == `XPR_PAGE_0) begin
            case (a)
                `XPR_ADDR_AB: decode_sel = xpr_sel_deriv;
                `XPR_ADDR_AC: decode_sel = xpr_sel_rev;
                default:      decode_sel = xpr_sel_none;
            endcase
        // page F bank of shared addresses
        end else if (pg == `XPR_PAGE_F) begin
            case (a)
                `XPR_ADDR_AB: decode_sel = xpr_sel_sn0;
                `XPR_ADDR_AC: decode_sel = xpr_sel_sn1;
                `XPR_ADDR_AD: decode_sel = xpr_sel_sn2;
                `XPR_ADDR_AE: decode_sel = xpr_sel_sn3;
                default:      decode_sel = xpr_sel_none;
            endcase
        end
    endfunction : decode_sel

    assign rd_sel = decode_sel(sfr_addr, register_page_selector);
    assign wr_sel = decode_sel(sfr_addr, register_page_selector);

    // page field register, reset to zero
    // only bits 1:0 are stored; upper write bits dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xram_page_field <= `XPR_PFIELD_RESET;
        end else if (sfr_wr && wr_sel == xpr_sel_page_ctrl) begin
            xram_page_field <= sfr_wdata[`XPR_PFIELD_MSB:`XPR_PFIELD_LSB];
        end
    end

    // serial register writes as general storage
    always_comb begin
        sn_wr_en  = 1'b0;
        sn_wr_idx = `XPR_SN_IDX0;
        case (wr_sel)
            xpr_sel_sn0: begin sn_wr_en = sfr_wr; sn_wr_idx = `XPR_SN_IDX0; end
            xpr_sel_sn1: begin sn_wr_en = sfr_wr; sn_wr_idx = `XPR_SN_IDX1; end
            xpr_sel_sn2: begin sn_wr_en = sfr_wr; sn_wr_idx = `XPR_SN_IDX2; end
            xpr_sel_sn3: begin sn_wr_en = sfr_wr; sn_wr_idx = `XPR_SN_IDX3; end
            default:     begin sn_wr_en = 1'b0; sn_wr_idx = `XPR_SN_IDX0; end
        endcase
    end

    xpr_sn_store u_xpr_sn_store (
        .mclk          (mclk),
        .rstn          (rstn),
        .sn_load       (sn_load),
        .sn_load_value (sn_load_value),
        .wr_en         (sn_wr_en),
        .wr_idx        (sn_wr_idx),
        .wr_data       (sfr_wdata),
        .sn_byte0      (sn_byte0),
        .sn_byte1      (sn_byte1),
        .sn_byte2      (sn_byte2),
        .sn_byte3      (sn_byte3)
    );

    // read mux; unmapped addresses return zero with no hit
    always_comb begin
        case (rd_sel)
            xpr_sel_page_ctrl: next_rdata = {`XPR_UPPER_ZERO, xram_page_field};
            xpr_sel_deriv:     next_rdata = DERIV_CODE;
            xpr_sel_rev:       next_rdata = REV_CODE;
            xpr_sel_sn0:       next_rdata = sn_byte0;
            xpr_sel_sn1:       next_rdata = sn_byte1;
            xpr_sel_sn2:       next_rdata = sn_byte2;
            xpr_sel_sn3:       next_rdata = sn_byte3;
            default:           next_rdata = `XPR_ZERO_BYTE;
        endcase
    end

    // read answer one cycle after the request, held until the next read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= `XPR_ZERO_BYTE;
            sfr_rack  <= 1'b0;
            sfr_rhit  <= 1'b0;
        end else begin
            sfr_rack <= sfr_rd;
            if (sfr_rd) begin
                sfr_rdata <= next_rdata;
                sfr_rhit  <= (rd_sel != xpr_sel_none);
            end
        end
    end

    // short moves take the page field as upper address byte
    // long moves wrap modulo the 1 kB array
    always_comb begin
        if (xmove_short) begin
            next_xaddr = {xram_page_field, xmove_addr[`XPR_SHORT_MSB:`XPR_ADDR_LSB]};
        end else begin
            next_xaddr = xmove_addr[`XPR_LONG_MSB:`XPR_ADDR_LSB];
        end
        next_unpop = (next_xaddr[`XPR_LONG_MSB:`XPR_XPAGE_LSB] == `XPR_UNPOP_PAGE);
    end

    // array request stage; writes to the empty page are dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xram_addr  <= `XPR_XADDR_RESET;
            xram_en    <= 1'b0;
            xram_we    <= 1'b0;
            xram_wdata <= `XPR_ZERO_BYTE;
            rd_pend1   <= 1'b0;
            unpop1     <= 1'b0;
        end else begin
            xram_en  <= external_data_move && !next_unpop;
            xram_we  <= external_data_move && xmove_wr && !next_unpop;
            rd_pend1 <= external_data_move && !xmove_wr;
            unpop1   <= next_unpop;
            if (external_data_move) begin
                xram_addr  <= next_xaddr;
                xram_wdata <= xmove_wdata;
            end
        end
    end

    // read return; unpopulated page yields zero, no array access
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_pend2     <= 1'b0;
            unpop2       <= 1'b0;
            xmove_rdata  <= `XPR_ZERO_BYTE;
            xmove_rvalid <= 1'b0;
        end else begin
            rd_pend2     <= rd_pend1;
            unpop2       <= unpop1;
            xmove_rvalid <= rd_pend2;
            if (rd_pend2) begin
                xmove_rdata <= unpop2 ? `XPR_ZERO_BYTE : xram_rdata;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence unpop_read_s;
        external_data_move && !xmove_wr && next_unpop;
    endsequence
    sequence zero_return_s;
        xmove_rvalid && xmove_rdata == `XPR_ZERO_BYTE;
    endsequence

    short_move_addr_a: assert property (
        external_data_move && xmove_short |=>
        xram_addr == {$past(xram_page_field), $past(xmove_addr[`XPR_SHORT_MSB:`XPR_ADDR_LSB])})
        else $error("short move upper byte not page field");
    // upper bits read zero after any write
    upper_bits_zero_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_PAGE_CTRL
        |=> sfr_rdata[`XPR_UPPER_MSB:`XPR_UPPER_LSB] == `XPR_UPPER_ZERO)
        else $error("page control upper bits not zero");
    // page control answers on any page
    page_ctrl_any_a: assert property (
        sfr_wr && sfr_addr == `XPR_ADDR_PAGE_CTRL ##1 sfr_rd && sfr_addr == `XPR_ADDR_PAGE_CTRL
        |=> sfr_rhit && sfr_rdata[`XPR_PFIELD_MSB:`XPR_PFIELD_LSB]
        == $past(sfr_wdata[`XPR_PFIELD_MSB:`XPR_PFIELD_LSB], 2))
        else $error("page control write not read back");
    deriv_code_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AB && register_page_selector == `XPR_PAGE_0
        |=> sfr_rack && sfr_rhit && sfr_rdata == DERIV_CODE)
        else $error("derivative code wrong");
    rev_code_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AC && register_page_selector == `XPR_PAGE_0
        |=> sfr_rdata == REV_CODE)
        else $error("revision code wrong");
    sn_byte3_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AE && register_page_selector == `XPR_PAGE_F
        |=> sfr_rdata == $past(sn_byte3))
        else $error("serial byte 3 wrong");
    sn_byte2_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AD && register_page_selector == `XPR_PAGE_F
        |=> sfr_rdata == $past(sn_byte2))
        else $error("serial byte 2 wrong");
    sn_byte1_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AC && register_page_selector == `XPR_PAGE_F
        |=> sfr_rdata == $past(sn_byte1))
        else $error("serial byte 1 wrong");
    sn_byte0_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AB && register_page_selector == `XPR_PAGE_F
        |=> sfr_rdata == $past(sn_byte0))
        else $error("serial byte 0 wrong");
    sn_store_a: assert property (
        sfr_wr && !sn_load && sfr_addr == `XPR_ADDR_AD
        && register_page_selector == `XPR_PAGE_F |=> sn_byte2 == $past(sfr_wdata))
        else $error("serial storage write lost");
    // empty page reads zero three cycles on
    unpop_zero_a: assert property (
        unpop_read_s |-> ##3 zero_return_s)
        else $error("unpopulated read not zero");
    // other pages give no shared-address hit
    other_page_a: assert property (
        sfr_rd && sfr_addr == `XPR_ADDR_AB && register_page_selector != `XPR_PAGE_0
        && register_page_selector != `XPR_PAGE_F |=> !sfr_rhit && sfr_rdata == `XPR_ZERO_BYTE)
        else $error("unpaged access hit");

endmodule : xpr_regs

// ===== hw/xpr_defines.svh
// constants for the xram page and device ident register bank
// assumes a byte-wide special function register space with paging
`ifndef XPR_DEFINES_SVH
`define XPR_DEFINES_SVH

// register addresses in the special function register space
`define XPR_ADDR_PAGE_CTRL  8'hAA
`define XPR_ADDR_AB         8'hAB
`define XPR_ADDR_AC         8'hAC
`define XPR_ADDR_AD         8'hAD
`define XPR_ADDR_AE         8'hAE

// register page codes
`define XPR_PAGE_0          8'h00
`define XPR_PAGE_F          8'h0F

// page field layout and reset
`define XPR_PFIELD_MSB      1
`define XPR_PFIELD_LSB      0
`define XPR_PFIELD_RESET    2'h0
`define XPR_UPPER_ZERO      6'h00
`define XPR_UPPER_MSB       7
`define XPR_UPPER_LSB       2

// xram address layout: byte offset, page bits, array top bit
`define XPR_ADDR_LSB        0
`define XPR_SHORT_MSB       7
`define XPR_XPAGE_LSB       8
`define XPR_LONG_MSB        9
`define XPR_XADDR_RESET     10'h000

// unpopulated xram page (0x0300 to 0x03FF)
`define XPR_UNPOP_PAGE      2'h3

// serial number storage
`define XPR_SN_RESET        8'h00
`define XPR_SN_BYTES        4
`define XPR_BYTE_W          8
`define XPR_SN_IDX0         2'h0
`define XPR_SN_IDX1         2'h1
`define XPR_SN_IDX2         2'h2
`define XPR_SN_IDX3         2'h3

// neutral byte value
`define XPR_ZERO_BYTE       8'h00

`endif

// ===== hw/xpr_pkg.sv
// types shared by the xram page and device ident register bank
// assumes xpr_defines.svh is on the include path
package xpr_pkg;

    typedef logic [7:0]  xpr_byte_t;
    typedef logic [1:0]  xpr_xram_page_field_t;
    typedef logic [1:0]  xpr_sn_idx_t;
    typedef logic [9:0]  xpr_xaddr_t;
    typedef logic [15:0] xpr_maddr_t;
    typedef logic [31:0] xpr_sn_t;

    // which register answers an access
    typedef enum logic [2:0] {
        xpr_sel_none,
        xpr_sel_page_ctrl,
        xpr_sel_deriv,
        xpr_sel_rev,
        xpr_sel_sn0,
        xpr_sel_sn1,
        xpr_sel_sn2,
        xpr_sel_sn3
    } xpr_sel_t;

endpackage : xpr_pkg

// ===== hw/xpr_sn_store.sv
// four byte serial number store, loaded once by production readout
// assumes load and core writes are single-cycle pulses on mclk
`timescale 1ns/1ns
`include "xpr_defines.svh"

module xpr_sn_store (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic                sn_load,
    input  wire xpr_pkg::xpr_sn_t    sn_load_value,
    input  wire logic                wr_en,
    input  wire xpr_pkg::xpr_sn_idx_t wr_idx,
    input  wire xpr_pkg::xpr_byte_t  wr_data,
    output xpr_pkg::xpr_byte_t       sn_byte0,
    output xpr_pkg::xpr_byte_t       sn_byte1,
    output xpr_pkg::xpr_byte_t       sn_byte2,
    output xpr_pkg::xpr_byte_t       sn_byte3
);
    import xpr_pkg::*;

    xpr_byte_t sn_mem [`XPR_SN_BYTES];

    // core writes reuse bytes as storage; load wins a tie
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `XPR_SN_BYTES; i++) begin
                sn_mem[i] <= `XPR_SN_RESET;
            end
        end else if (sn_load) begin
            for (int i = 0; i < `XPR_SN_BYTES; i++) begin
                sn_mem[i] <= sn_load_value[i*`XPR_BYTE_W +: `XPR_BYTE_W];
            end
        end else if (wr_en) begin
            sn_mem[wr_idx] <= wr_data;
        end
    end

    // outputs are the storage flops themselves
    assign sn_byte0 = sn_mem[`XPR_SN_IDX0];
    assign sn_byte1 = sn_mem[`XPR_SN_IDX1];
    assign sn_byte2 = sn_mem[`XPR_SN_IDX2];
    assign sn_byte3 = sn_mem[`XPR_SN_IDX3];

    sn_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        sn_load |=> {sn_byte3, sn_byte2, sn_byte1, sn_byte0} == $past(sn_load_value))
        else $error("serial number load not stored");

endmodule : xpr_sn_store

// ===== dv/xpr_xram_model.sv
// behavioural xram array standing behind the external data move port
// assumes one enable pulse per access and a synchronous read on mclk
`timescale 1ns/1ns

module xpr_xram_model (
    input  wire logic                mclk,
    input  wire xpr_pkg::xpr_xaddr_t xram_addr,
    input  wire logic                xram_en,
    input  wire logic                xram_we,
    input  wire xpr_pkg::xpr_byte_t  xram_wdata,
    output xpr_pkg::xpr_byte_t       xram_rdata
);
    import xpr_pkg::*;

    xpr_byte_t mem [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'h00;
        end
        xram_rdata = 8'h00;
    end

    // sync read; between reads the output toggles so stale data never looks valid
    always @(posedge mclk) begin
        if (xram_en === 1'b1 && xram_we === 1'b1) begin
            mem[xram_addr] <= xram_wdata;
        end
        if (xram_en === 1'b1 && xram_we === 1'b0) begin
            xram_rdata <= mem[xram_addr];
        end else begin
            xram_rdata <= ~xram_rdata;
        end
    end
endmodule : xpr_xram_model

// ===== dv/xpr_regs_tb.sv
// self-checking bench for the xram page and ident register bank
// assumes xpr_pkg is compiled first and xpr_defines.svh is on the include path
`timescale 1ns/1ns
`include "xpr_defines.svh"

module xpr_regs_tb;
    import xpr_pkg::*;

    localparam xpr_byte_t DERIV = 8'h5A;  // arbitrary value
    localparam xpr_byte_t REV   = 8'h3C;  // arbitrary value

    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    xpr_byte_t  register_page_selector = 8'h00;
    xpr_byte_t  sfr_addr = 8'h00;
    logic       sfr_rd = 1'b0;
    logic       sfr_wr = 1'b0;
    xpr_byte_t  sfr_wdata = 8'h00;
    xpr_byte_t  sfr_rdata;
    logic       sfr_rack;
    logic       sfr_rhit;
    logic       sn_load = 1'b0;
    xpr_sn_t    sn_load_value = 32'h0;
    logic       external_data_move = 1'b0;
    logic       xmove_short = 1'b0;
    logic       xmove_wr = 1'b0;
    xpr_maddr_t xmove_addr = 16'h0;
    xpr_byte_t  xmove_wdata = 8'h00;
    xpr_xaddr_t xram_addr;
    logic       xram_en;
    logic       xram_we;
    xpr_byte_t  xram_wdata;
    xpr_byte_t  xram_rdata;
    xpr_byte_t  xmove_rdata;
    logic       xmove_rvalid;
    xpr_xram_page_field_t xram_page_field;
    int         mismatches = 0;
    int         checks = 0;
    int         en_cnt = 0;
    xpr_xaddr_t en_addr;
    xpr_byte_t  en_wd;
    xpr_byte_t  d;
    int         c;
    xpr_sn_t    sn;

    xpr_regs #(.DERIV_CODE(DERIV), .REV_CODE(REV)) u_xpr_regs (
        .mclk(mclk), .rstn(rstn), .register_page_selector(register_page_selector),
        .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_rack(sfr_rack), .sfr_rhit(sfr_rhit),
        .sn_load(sn_load), .sn_load_value(sn_load_value),
        .external_data_move(external_data_move), .xmove_short(xmove_short),
        .xmove_wr(xmove_wr), .xmove_addr(xmove_addr), .xmove_wdata(xmove_wdata),
        .xram_addr(xram_addr), .xram_en(xram_en), .xram_we(xram_we),
        .xram_wdata(xram_wdata), .xram_rdata(xram_rdata), .xmove_rdata(xmove_rdata),
        .xmove_rvalid(xmove_rvalid), .xram_page_field(xram_page_field));

    xpr_xram_model u_xpr_xram_model (
        .mclk(mclk), .xram_addr(xram_addr), .xram_en(xram_en), .xram_we(xram_we),
        .xram_wdata(xram_wdata), .xram_rdata(xram_rdata));

    // clock at 8 ns period
    initial begin
        forever #4 mclk = ~mclk;
    end

    // record every array access the block launches
    always @(posedge mclk) begin
        if (xram_en === 1'b1) begin
            en_cnt  <= en_cnt + 1;
            en_addr <= xram_addr;
            en_wd   <= xram_wdata;
        end
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic sfr_write(input xpr_byte_t page, input xpr_byte_t addr, input xpr_byte_t wd);
        @(posedge mclk);
        register_page_selector <= page;
        sfr_addr  <= addr;
        sfr_wdata <= wd;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : sfr_write

    // read and compare data and hit flag; ack wait is bounded
    task automatic rd_chk(input xpr_byte_t page, input xpr_byte_t addr,
                          input xpr_byte_t exp, input logic hit);
        int n;
        @(posedge mclk);
        register_page_selector <= page;
        sfr_addr <= addr;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        n = 0;
        #1;
        while (sfr_rack !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 4) begin
            mismatches++;
            final_report();
        end else begin
            check("sfr_rdata", 16'(sfr_rdata), 16'(exp));
            check("sfr_rhit", 16'(sfr_rhit), 16'(hit));
        end
    endtask : rd_chk

    // one external data move; reads wait a bounded time for the result
    task automatic xmove(input logic sh, input logic wr, input xpr_maddr_t a,
                         input xpr_byte_t wd, output xpr_byte_t rd);
        int n;
        @(posedge mclk);
        external_data_move <= 1'b1;
        xmove_short <= sh;
        xmove_wr    <= wr;
        xmove_addr  <= a;
        xmove_wdata <= wd;
        @(posedge mclk);
        external_data_move <= 1'b0;
        n = 0;
        #1;
        while (xmove_rvalid !== 1'b1 && n < 6) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 6 && wr == 1'b0) begin
            mismatches++;
            final_report();
        end else begin
            rd = xmove_rdata;
        end
    endtask : xmove

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_PAGE_CTRL, 8'h00, 1'b1);
        sfr_write(`XPR_PAGE_0, `XPR_ADDR_PAGE_CTRL, 8'hFD);
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_PAGE_CTRL, 8'h01, 1'b1);
        check("page_field", 16'(xram_page_field), 16'h1);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AB, DERIV, 1'b1);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AC, REV, 1'b1);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AD, 8'h00, 1'b0);
        rd_chk(8'h05, `XPR_ADDR_AB, 8'h00, 1'b0);
        // production load, then each byte on page F
        sn = 32'h4433_2211;
        @(posedge mclk);
        sn_load <= 1'b1;
        sn_load_value <= sn;
        @(posedge mclk);
        sn_load <= 1'b0;
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_AB, sn[7:0], 1'b1);
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_AC, sn[15:8], 1'b1);
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_AD, sn[23:16], 1'b1);
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_AE, sn[31:24], 1'b1);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AC, REV, 1'b1);
        for (int i = 0; i < 4; i++) begin
            sfr_write(`XPR_PAGE_F, 8'(`XPR_ADDR_AB + i), 8'(8'hC0 + i));
            rd_chk(`XPR_PAGE_F, 8'(`XPR_ADDR_AB + i), 8'(8'hC0 + i), 1'b1);
        end
        // page 0 writes to ident codes must not land anywhere
        sfr_write(`XPR_PAGE_0, `XPR_ADDR_AB, 8'hEE);
        sfr_write(`XPR_PAGE_0, `XPR_ADDR_AC, 8'hEE);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AB, DERIV, 1'b1);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_AC, REV, 1'b1);
        rd_chk(`XPR_PAGE_F, `XPR_ADDR_AB, 8'hC0, 1'b1);
        // long write, short read through page 1 with junk upper byte
        xmove(1'b0, 1'b1, 16'h0105, 8'hA5, d);
        check("xram_addr", 16'(en_addr), 16'h0105);
        check("xram_wdata", 16'(en_wd), 16'h00A5);
        xmove(1'b1, 1'b0, 16'hFF05, 8'h00, d);
        check("short_rd", 16'(d), 16'h00A5);
        // back-to-back write then read of page control, across pages
        @(posedge mclk);
        register_page_selector <= `XPR_PAGE_F;
        sfr_addr  <= `XPR_ADDR_PAGE_CTRL;
        sfr_wdata <= 8'hFE;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        register_page_selector <= `XPR_PAGE_0;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1;
        check("b2b_rack", 16'(sfr_rack), 16'h0001);
        check("b2b_rdata", 16'(sfr_rdata), 16'h0002);
        rd_chk(`XPR_PAGE_0, `XPR_ADDR_PAGE_CTRL, 8'h02, 1'b1);
        xmove(1'b1, 1'b1, 16'h0010, 8'h5C, d);
        check("xram_addr", 16'(en_addr), 16'h0210);
        xmove(1'b0, 1'b0, 16'h0610, 8'h00, d);
        check("long_wrap_rd", 16'(d), 16'h005C);
        // page 3 is unpopulated: no array access, reads give zero
        sfr_write(`XPR_PAGE_0, `XPR_ADDR_PAGE_CTRL, 8'h03);
        c = en_cnt;
        xmove(1'b1, 1'b0, 16'h0020, 8'h00, d);
        check("page3_rd", 16'(d), 16'h0000);
        xmove(1'b1, 1'b1, 16'h0021, 8'h77, d);
        xmove(1'b0, 1'b0, 16'h07FF, 8'h00, d);
        check("long_3ff_rd", 16'(d), 16'h0000);
        check("xram_en_cnt", 16'(en_cnt - c), 16'h0000);
        final_report();
    end
endmodule : xpr_regs_tb
